//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module tb_top;
   // ***
   // Bench
   // ***
   logic       clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [1:0] ovf_serviced_i = 2'b00;
   logic [2:0] capsel = 3'h0;
   logic [7:0] rdata, vec;
   logic [1:0] ovf_irq, mc_irq, pin, eclk, cap;
   logic       lvl3;
   int         num_errors = 0;
   int         num_checks = 0;
   always #12.5 clk_i = ~clk_i;
   tdt_timer u_dut (
      .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .ovf_serviced_i(ovf_serviced_i),
      .overflow_irq_o(ovf_irq), .match_capture_irq_o(mc_irq),
      .interrupt_level_three_o(lvl3), .irq_vector_o(vec), .port3_low_capsel_i(capsel),
      .ext_clock_pin_i(eclk), .capture_pin_i(cap), .toggle_pin_o(pin));
   tdt_pin_model u_pins (.clk_i(clk_i), .cap_o(cap), .eclk_o(eclk));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      repeat (2) @(posedge clk_i);
      #1 d = rdata;
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd(a, v[15:8]);
      rd(a + 8'h01, v[7:0]);
   endtask
   // Reference counter: one step per tick, interval mode clears on match
   function automatic void run(input int r, k, input bit pwm, output int c, m);
      c = 0;
      m = 0;
      repeat (k) begin
         if (!pwm && c == r) begin
            c = 0;
            m++;
         end else
            c = (c + 1) % 65536;
      end
   endfunction
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_mc(input int t);
      int k;
      for (k = 0; k < 20 && mc_irq[t] !== 1'b1; k++)
         @(posedge clk_i);
      if (k == 20) begin
         num_errors++;
         $display("[ERR] %0t capture never seen", $time);
         close_out();
      end
   endtask
   initial begin
      logic [7:0]  d;
      logic [15:0] v;
      int          cnt, m, r, x, n;
      int          dv [6] = '{1024, 256, 64, 8, 1, 8};
      int          rf [2];
      void'($urandom(44333));
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      foreach (dv[i]) begin
         rd(i < 2 ? 8'hFA + 8'(i) : 8'(i - 2) * 8'hF1, d);
         `CHK(d, 8'h00)
      end
      wr(8'hFA, 8'h84);
      rd(8'hFA, d);
      `CHK(d, 8'h80)
      wr(8'hF5, 8'hFF);
      wr(8'hF4, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         wr(8'hFA, {(i < 5) ? 3'(i) : 3'h7, 5'h04});
         repeat (3 * dv[i] - 2) @(posedge clk_i);
         wr(8'hFA, 8'hE0);
         rd16(8'hF2, v);
         `CHK(v, (i < 5) ? 16'h0003 : 16'h0000)
      end
      $display("test prescaler done");
      // Second reset: output flops restart low, so toggle parity is known
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(8'hFA, d);
      `CHK(d, 8'h00)
      for (int t = 0; t < 2; t++) begin
         r = 2 + $urandom % 8;
         x = 20 + $urandom % 40;
         wr(8'hF4 + 8'(4 * t), 8'h00);
         wr(8'hF5 + 8'(4 * t), 8'(r));
         wr(8'hFA + 8'(t), 8'h86);
         repeat (x - 2) @(posedge clk_i);
         wr(8'hFA + 8'(t), 8'hE2);
         run(r, x, 0, cnt, m);
         rd16(8'hF2 + 8'(4 * t), v);
         `CHK(v, 16'(cnt))
         `CHK(pin[t], 1'(m))
         `CHK(mc_irq, 2'(1 << t))
         wr(8'hF1, 8'h00);
         #1 `CHK(mc_irq, 2'b00)
      end
      $display("test interval done");
      for (int t = 0; t < 2; t++)
         for (int e = 0; e < 2; e++) begin
            n = 3 + $urandom % 6;
            wr(8'hFA + 8'(t), {3'(5 + e), 5'h1C});
            u_pins.pulses(t, n);
            repeat (6) @(posedge clk_i);
            wr(8'hFA + 8'(t), 8'hF8);
            rd16(8'hF2 + 8'(4 * t), v);
            `CHK(v, 16'(n))
         end
      $display("test external clock done");
      for (int t = 0; t < 2; t++) begin
         x = 20 + $urandom % 40;
         wr(8'hFA + 8'(t), 8'h9C);
         repeat (x - 2) @(posedge clk_i);
         wr(8'hFA + 8'(t), 8'hEA);
         wr(8'hF1, 8'h00);
         capsel <= 3'h1;
         u_pins.set_cap(t, 1'b1);
         u_pins.set_cap(t, 1'b0);
         `CHK(mc_irq[t], 1'(t))
         wr(8'hF1, 8'h00);
         capsel <= 3'h0;
         u_pins.set_cap(t, 1'b1);
         wait_mc(t);
         rd16(8'hF4 + 8'(4 * t), v);
         `CHK(v, 16'(x))
         wr(8'hFA + 8'(t), 8'hF6);
         wr(8'hF1, 8'h00);
         u_pins.set_cap(t, 1'b0);
         wait_mc(t);
         rd(8'hF1, d);
         `CHK(d, (t != 0) ? 8'h20 : 8'h08)
         rd16(8'hF4 + 8'(4 * t), v);
         `CHK(v, 16'h0000)
      end
      $display("test capture done");
      wr(8'hF1, 8'h00);
      x = 1 + $urandom % 200;
      for (int t = 0; t < 2; t++) begin
         rf[t] = $urandom % 400;
         wr(8'hF4 + 8'(4 * t), 8'(rf[t] >> 8));
         wr(8'hF5 + 8'(4 * t), 8'(rf[t]));
      end
      wr(8'hFA, 8'h9C);
      wr(8'hFB, 8'h9C);
      repeat (65536 + x - 4) @(posedge clk_i);
      wr(8'hFA, 8'hF8);
      wr(8'hFB, 8'hF8);
      run(0, 65536 + x, 1, cnt, m);
      for (int t = 0; t < 2; t++) begin
         rd16(8'hF2 + 8'(4 * t), v);
         `CHK(v, 16'(cnt))
         `CHK(pin[t], 1'(rf[t] > cnt))
      end
      wr(8'hFB, 8'hF9);
      #1 `CHK(ovf_irq, 2'b10)
      `CHK(vec, 8'hDE)
      `CHK(lvl3, 1'b1)
      @(posedge clk_i);
      ovf_serviced_i <= 2'b10;
      @(posedge clk_i);
      ovf_serviced_i <= 2'b00;
      #1 `CHK(ovf_irq, 2'b00)
      wr(8'hFA, 8'hF9);
      #1 `CHK(ovf_irq, 2'b01)
      `CHK(vec, 8'hDA)
      wr(8'hF1, 8'hFB);
      #1 `CHK(ovf_irq, 2'b00)
      rd(8'hF1, d);
      `CHK(d, 8'h28)
      $display("test overflow done");
      close_out();
   end
endmodule // tb_top

//--- tdt_pin_model.sv
`timescale 1ns/1ps
// ***
// Pin driver for capture and external clock inputs
// ***
module tdt_pin_model (
   // Clock
   input  wire logic       clk_i,
   // Pins, idle low, still between uses
   output logic      [1:0] cap_o,
   output logic      [1:0] eclk_o
);
   initial begin
      cap_o  = 2'b00;
      eclk_o = 2'b00;
   end
   // Levels held 4 cycles so the two-flop sync never misses an edge
   task automatic set_cap(input int t, input logic v);
      @(posedge clk_i);
      cap_o[t] <= v;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic pulses(input int t, input int n);
      repeat (n) begin
         @(posedge clk_i);
         eclk_o[t] <= 1'b1;
         repeat (4) @(posedge clk_i);
         eclk_o[t] <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule // tdt_pin_model

//--- tdt_pkg.sv
package tdt_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] TDT_CTRL_ADDR [2] = '{8'hFA, 8'hFB};
   localparam logic [7:0] TDT_CNTH_ADDR [2] = '{8'hF2, 8'hF6};
   localparam logic [7:0] TDT_CNTL_ADDR [2] = '{8'hF3, 8'hF7};
   localparam logic [7:0] TDT_REFH_ADDR [2] = '{8'hF4, 8'hF8};
   localparam logic [7:0] TDT_REFL_ADDR [2] = '{8'hF5, 8'hF9};
   localparam logic [7:0] TDT_PEND_ADDR      = 8'hF1;
   localparam logic [7:0] TDT_CTRL_RESET     = 8'h00;
   // ****************************************
   // Control fields
   // ****************************************
   localparam int TDT_CSEL_MSB = 7;
   localparam int TDT_CSEL_LSB = 5;
   localparam int TDT_MODE_MSB = 4;
   localparam int TDT_MODE_LSB = 3;
   localparam int TDT_CLR_BIT  = 2;
   localparam int TDT_MCIE_BIT = 1;
   localparam int TDT_OVIE_BIT = 0;
   localparam logic [2:0] TDT_CS_DIV1024 = 3'h0;
   localparam logic [2:0] TDT_CS_DIV256  = 3'h1;
   localparam logic [2:0] TDT_CS_DIV64   = 3'h2;
   localparam logic [2:0] TDT_CS_DIV8    = 3'h3;
   localparam logic [2:0] TDT_CS_DIV1    = 3'h4;
   localparam logic [2:0] TDT_CS_EXTR    = 3'h5;
   localparam logic [2:0] TDT_CS_EXTF    = 3'h6;
   localparam logic [2:0] TDT_CS_STOP    = 3'h7;
   localparam logic [1:0] TDT_MD_INTERVAL = 2'h0;
   localparam logic [1:0] TDT_MD_CAPRISE  = 2'h1;
   localparam logic [1:0] TDT_MD_CAPFALL  = 2'h2;
   localparam logic [1:0] TDT_MD_PWM      = 2'h3;
   // ****************************************
   // Prescaler masks and pending bits
   // ****************************************
   localparam logic [9:0] TDT_MASK1024 = 10'h3FF;
   localparam logic [9:0] TDT_MASK256  = 10'h0FF;
   localparam logic [9:0] TDT_MASK64   = 10'h03F;
   localparam logic [9:0] TDT_MASK8    = 10'h007;
   localparam int TDT_OVF_PEND [2] = '{2, 4};
   localparam int TDT_MC_PEND  [2] = '{3, 5};
   localparam logic [2:0] TDT_CAPSEL_PIN = 3'h0;
   localparam logic [15:0] TDT_CNT_MAX   = 16'hFFFF;
   localparam logic [15:0] TDT_CNT_ZERO  = 16'h0000;
   // ****************************************
   // Level 3 vectors
   // ****************************************
   localparam logic [7:0] TDT_VEC_OVF [2] = '{8'hDA, 8'hDE};
   localparam logic [7:0] TDT_VEC_MC  [2] = '{8'hD8, 8'hDC};
   localparam logic [7:0] TDT_VEC_NONE    = 8'h00;
endpackage : tdt_pkg

//--- tdt_timer.sv
`timescale 1ns/1ps
module tdt_timer #(
   parameter int NUM_TIMERS = 2,
   parameter int CNT_W      = 16
) (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   // Register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic                  reg_wr_i,
   input  wire logic [7:0]            reg_wdata_i,
   output logic      [7:0]            reg_rdata_o,
   // Interrupt service
   input  wire logic [NUM_TIMERS-1:0] ovf_serviced_i,
   output logic      [NUM_TIMERS-1:0] overflow_irq_o,
   output logic      [NUM_TIMERS-1:0] match_capture_irq_o,
   output logic                       interrupt_level_three_o,
   output logic      [7:0]            irq_vector_o,
   // Pins
   input  wire logic [2:0]            port3_low_capsel_i,
   input  wire logic [NUM_TIMERS-1:0] ext_clock_pin_i,
   input  wire logic [NUM_TIMERS-1:0] capture_pin_i,
   output logic      [NUM_TIMERS-1:0] toggle_pin_o
);
   // ****************************************
   // Shared prescaler
   // ****************************************
   logic [9:0] presc_ff;
   logic [9:0] nxt_presc;

   always_comb begin
      nxt_presc = presc_ff + 10'h001;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= nxt_presc;
      end
   end

   localparam int TDT_CSEL_MSB_L = tdt_pkg::TDT_CSEL_MSB;
   localparam int TDT_CSEL_LSB_L = tdt_pkg::TDT_CSEL_LSB;
   localparam int TDT_MODE_MSB_L = tdt_pkg::TDT_MODE_MSB;
   localparam int TDT_MODE_LSB_L = tdt_pkg::TDT_MODE_LSB;
   localparam int TDT_CLR_BIT_L  = tdt_pkg::TDT_CLR_BIT;

   // ****************************************
   // Per-timer state
   // ****************************************
   logic [NUM_TIMERS-1:0][7:0]       ctrl_ff;
   logic [NUM_TIMERS-1:0][CNT_W-1:0] cnt_ff;
   logic [NUM_TIMERS-1:0][CNT_W-1:0] ref_ff;
   logic [NUM_TIMERS-1:0]            ovf_ev;
   logic [NUM_TIMERS-1:0]            mc_ev;

   for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
      logic [7:0]       nxt_ctrl;
      logic [CNT_W-1:0] nxt_cnt;
      logic [CNT_W-1:0] nxt_ref;
      logic             out_ff;
      logic             nxt_out;
      // Pins are asynchronous: two flops, then a third stage for edges
      logic [2:0]       clk_sync_ff;
      logic [2:0]       cap_sync_ff;
      logic             tick;
      logic             cap_edge;
      logic             cap_ok;
      logic [2:0]       csel;
      logic [1:0]       mode;

      always_comb begin
         csel     = ctrl_ff[i][TDT_CSEL_MSB_L:TDT_CSEL_LSB_L];
         mode     = ctrl_ff[i][TDT_MODE_MSB_L:TDT_MODE_LSB_L];
         nxt_ctrl = ctrl_ff[i];
         nxt_cnt  = cnt_ff[i];
         nxt_ref  = ref_ff[i];
         nxt_out  = out_ff;
         ovf_ev[i] = 1'b0;
         mc_ev[i]  = 1'b0;
         unique case (csel)
            tdt_pkg::TDT_CS_DIV1024: tick = ((presc_ff & tdt_pkg::TDT_MASK1024)
                                            == tdt_pkg::TDT_MASK1024);
            tdt_pkg::TDT_CS_DIV256:  tick = ((presc_ff & tdt_pkg::TDT_MASK256)
                                            == tdt_pkg::TDT_MASK256);
            tdt_pkg::TDT_CS_DIV64:   tick = ((presc_ff & tdt_pkg::TDT_MASK64)
                                            == tdt_pkg::TDT_MASK64);
            tdt_pkg::TDT_CS_DIV8:    tick = ((presc_ff & tdt_pkg::TDT_MASK8)
                                            == tdt_pkg::TDT_MASK8);
            tdt_pkg::TDT_CS_DIV1:    tick = 1'b1;
            tdt_pkg::TDT_CS_EXTR:    tick = clk_sync_ff[1] & ~clk_sync_ff[2];
            tdt_pkg::TDT_CS_EXTF:    tick = ~clk_sync_ff[1] & clk_sync_ff[2];
            tdt_pkg::TDT_CS_STOP:    tick = 1'b0;
         endcase
         // Timer 0 capture source select lies outside this block
         cap_ok   = (i != 0) || (port3_low_capsel_i == tdt_pkg::TDT_CAPSEL_PIN);
         cap_edge = cap_ok && (((mode == tdt_pkg::TDT_MD_CAPRISE) && cap_sync_ff[1]
                                && !cap_sync_ff[2]) ||
                               ((mode == tdt_pkg::TDT_MD_CAPFALL) && !cap_sync_ff[1]
                                && cap_sync_ff[2]));
         if (reg_wr_i && (reg_addr_i == tdt_pkg::TDT_CTRL_ADDR[i])) begin
            // Clear bit is a strobe, so it never reads back as one
            nxt_ctrl = reg_wdata_i;
            nxt_ctrl[TDT_CLR_BIT_L] = 1'b0;
         end
         if (reg_wr_i && (reg_addr_i == tdt_pkg::TDT_REFH_ADDR[i])) begin
            nxt_ref[CNT_W-1:8] = reg_wdata_i;
         end
         if (reg_wr_i && (reg_addr_i == tdt_pkg::TDT_REFL_ADDR[i])) begin
            nxt_ref[7:0] = reg_wdata_i;
         end
         if (tick) begin
            if ((mode == tdt_pkg::TDT_MD_INTERVAL) && (cnt_ff[i] == ref_ff[i])) begin
               nxt_cnt   = tdt_pkg::TDT_CNT_ZERO;
               mc_ev[i]  = 1'b1;
               nxt_out   = ~out_ff;
            end else begin
               nxt_cnt = cnt_ff[i] + 16'h0001;
               if (cnt_ff[i] == tdt_pkg::TDT_CNT_MAX) begin
                  ovf_ev[i] = 1'b1;
               end
               if ((mode == tdt_pkg::TDT_MD_PWM) && (cnt_ff[i] == ref_ff[i])) begin
                  mc_ev[i] = 1'b1;
               end
            end
         end
         if (cap_edge) begin
            nxt_ref  = cnt_ff[i];
            mc_ev[i] = 1'b1;
         end
         if (mode == tdt_pkg::TDT_MD_PWM) begin
            nxt_out = (ref_ff[i] > nxt_cnt);
         end
         // A clear write wins over a coincident count step
         if (reg_wr_i && (reg_addr_i == tdt_pkg::TDT_CTRL_ADDR[i])
             && reg_wdata_i[TDT_CLR_BIT_L]) begin
            nxt_cnt = tdt_pkg::TDT_CNT_ZERO;
         end
      end

      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            ctrl_ff[i]  <= tdt_pkg::TDT_CTRL_RESET;
            cnt_ff[i]   <= '0;
            ref_ff[i]   <= '0;
            out_ff      <= 1'b0;
            clk_sync_ff <= '0;
            cap_sync_ff <= '0;
         end else begin
            ctrl_ff[i]  <= nxt_ctrl;
            cnt_ff[i]   <= nxt_cnt;
            ref_ff[i]   <= nxt_ref;
            out_ff      <= nxt_out;
            clk_sync_ff <= {clk_sync_ff[1:0], ext_clock_pin_i[i]};
            cap_sync_ff <= {cap_sync_ff[1:0], capture_pin_i[i]};
         end
      end

      // PWM and interval share one pin
      assign toggle_pin_o[i] = out_ff;
   end : g_tmr

   // ****************************************
   // Shared pending flags
   // ****************************************
   logic [7:0] pend_ff;
   logic [7:0] nxt_pend;

   always_comb begin
      nxt_pend = pend_ff;
      if (reg_wr_i && (reg_addr_i == tdt_pkg::TDT_PEND_ADDR)) begin
         // Writing one leaves a flag alone; only zero clears
         nxt_pend = pend_ff & reg_wdata_i;
      end
      for (int k = 0; k < NUM_TIMERS; k++) begin
         if (ovf_serviced_i[k]) begin
            nxt_pend[tdt_pkg::TDT_OVF_PEND[k]] = 1'b0;
         end
         // Set after clear, so a same-cycle event is never lost
         if (ovf_ev[k]) begin
            nxt_pend[tdt_pkg::TDT_OVF_PEND[k]] = 1'b1;
         end
         if (mc_ev[k]) begin
            nxt_pend[tdt_pkg::TDT_MC_PEND[k]] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= nxt_pend & 8'h3C;
      end
   end

   // ****************************************
   // Interrupt requests
   // ****************************************
   always_comb begin
      irq_vector_o = tdt_pkg::TDT_VEC_NONE;
      for (int k = NUM_TIMERS - 1; k >= 0; k--) begin
         overflow_irq_o[k] = pend_ff[tdt_pkg::TDT_OVF_PEND[k]]
                             & ctrl_ff[k][tdt_pkg::TDT_OVIE_BIT];
         match_capture_irq_o[k] = pend_ff[tdt_pkg::TDT_MC_PEND[k]]
                                  & ctrl_ff[k][tdt_pkg::TDT_MCIE_BIT];
         // Lowest vector address has the highest priority
         if (overflow_irq_o[k]) begin
            irq_vector_o = tdt_pkg::TDT_VEC_OVF[k];
         end
         if (match_capture_irq_o[k]) begin
            irq_vector_o = tdt_pkg::TDT_VEC_MC[k];
         end
      end
      interrupt_level_three_o = |overflow_irq_o | |match_capture_irq_o;
   end

   // ****************************************
   // Read back
   // ****************************************
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 8'h00;
      if (reg_addr_i == tdt_pkg::TDT_PEND_ADDR) begin
         nxt_rdata = pend_ff;
      end
      for (int k = 0; k < NUM_TIMERS; k++) begin
         if (reg_addr_i == tdt_pkg::TDT_CTRL_ADDR[k]) begin
            nxt_rdata = ctrl_ff[k];
         end
         if (reg_addr_i == tdt_pkg::TDT_CNTH_ADDR[k]) begin
            nxt_rdata = cnt_ff[k][CNT_W-1:8];
         end
         if (reg_addr_i == tdt_pkg::TDT_CNTL_ADDR[k]) begin
            nxt_rdata = cnt_ff[k][7:0];
         end
         if (reg_addr_i == tdt_pkg::TDT_REFH_ADDR[k]) begin
            nxt_rdata = ref_ff[k][CNT_W-1:8];
         end
         if (reg_addr_i == tdt_pkg::TDT_REFL_ADDR[k]) begin
            nxt_rdata = ref_ff[k][7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;
endmodule // tdt_timer

//--- tdt_timer_checker.sv
`timescale 1ns/1ps
module tdt_timer_checker #(
   parameter int NUM_TIMERS = 2,
   parameter int CNT_W      = 16
) (
   // Watched ports
   input wire logic                  clk_i,
   input wire logic                  srst_i,
   input wire logic [7:0]            reg_addr_i,
   input wire logic                  reg_wr_i,
   input wire logic [7:0]            reg_wdata_i,
   input wire logic [7:0]            reg_rdata_o,
   input wire logic [NUM_TIMERS-1:0] ovf_serviced_i,
   input wire logic [NUM_TIMERS-1:0] overflow_irq_o,
   input wire logic [NUM_TIMERS-1:0] match_capture_irq_o,
   input wire logic                  interrupt_level_three_o,
   input wire logic [7:0]            irq_vector_o,
   input wire logic [NUM_TIMERS-1:0] toggle_pin_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   a_level_or: assert property (
      interrupt_level_three_o == (|{overflow_irq_o, match_capture_irq_o}))
      else $error("level three request wrong");
   a_vec_t0: assert property (
      ({overflow_irq_o, match_capture_irq_o} == 4'h4 |-> irq_vector_o == 8'hDA) and
      ({overflow_irq_o, match_capture_irq_o} == 4'h1 |-> irq_vector_o == 8'hD8))
      else $error("timer 0 vector wrong");
   a_vec_t1: assert property (
      ({overflow_irq_o, match_capture_irq_o} == 4'h8 |-> irq_vector_o == 8'hDE) and
      ({overflow_irq_o, match_capture_irq_o} == 4'h2 |-> irq_vector_o == 8'hDC))
      else $error("timer 1 vector wrong");
   a_vec_none: assert property (
      {overflow_irq_o, match_capture_irq_o} == 4'h0 |-> irq_vector_o == 8'h00)
      else $error("vector without request");
   a_reset_quiet: assert property (
      $past(srst_i) |-> toggle_pin_o == 2'b00 && (overflow_irq_o | match_capture_irq_o) == 2'b00)
      else $error("outputs not quiet after reset");
   a_ctrl_read: assert property (
      reg_wr_i && reg_addr_i == 8'hFA ##1 !reg_wr_i && reg_addr_i == 8'hFA
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hFB))
      else $error("control readback wrong");
   a_pend_rsvd: assert property (
      reg_addr_i == 8'hF1 |=> (reg_rdata_o & 8'hC3) == 8'h00)
      else $error("pending spare bits set");
   a_unmapped_zero: assert property (
      reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_mc_sticky: assert property (
      |($past(match_capture_irq_o) & ~match_capture_irq_o) |-> $past(reg_wr_i))
      else $error("match request dropped by itself");
   a_ovf_clear: assert property (
      $fell(overflow_irq_o[0]) |-> $past(reg_wr_i) || $past(ovf_serviced_i[0]))
      else $error("overflow request dropped by itself");
endmodule // tdt_timer_checker
bind tdt_timer tdt_timer_checker #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) u_chk (
   .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .ovf_serviced_i(ovf_serviced_i),
   .overflow_irq_o(overflow_irq_o), .match_capture_irq_o(match_capture_irq_o),
   .interrupt_level_three_o(interrupt_level_three_o), .irq_vector_o(irq_vector_o),
   .toggle_pin_o(toggle_pin_o));
